// ==== hw/sfif_frontend.sv ====
// serial flash instruction front end: capture, decode, terminate
`timescale 1ns/10ps
`include "sfif_params.svh"

module sfif_frontend
	import sfif_pkg::*;
#(
	parameter logic [7:0] DEVICE_CODE = 8'h5a // arbitrary value
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// host link
	input  wire logic        select_b,
	input  wire logic [3:0]  dq_in,
	output logic      [3:0]  dq_out,
	output logic      [3:0]  dq_oe_b,
	// array side status
	input  wire logic        busy,
	input  wire logic        quad_enable_bit,
	input  wire logic [7:0]  status_low_byte,
	input  wire logic [7:0]  status_high_byte,
	input  wire logic        addr_protected,
	// decoded operations
	output logic             write_enable,
	output logic             vsr_write_enable,
	output logic             four_bit_command_mode,
	output logic             power_down,
	output logic             cmd_program,
	output logic             cmd_erase,
	output logic             cmd_write_status,
	output logic      [7:0]  cmd_opcode,
	output logic      [23:0] cmd_addr,
	output logic             data_valid,
	output logic      [7:0]  data_byte,
	output logic      [7:0]  page_offset,
	output logic      [7:0]  status_write_byte
);

	// ----------------------------------------------------------------
	// input synchronisers and reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic       rst_n;
	logic       sel_s1, sel_s2, sel_d;
	logic [3:0] dq_s1, dq_s2;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_s1 <= 1'b1;
			sel_s2 <= 1'b1;
			sel_d  <= 1'b1;
			dq_s1  <= 4'h0;
			dq_s2  <= 4'h0;
		end
		else
		begin
			sel_s1 <= select_b;
			sel_s2 <= sel_s1;
			sel_d  <= sel_s2;
			dq_s1  <= dq_in;
			dq_s2  <= dq_s1;
		end
	end

	// select edges come straight off the synchroniser, sel_d holding its last value; dq lags equally
	logic sel_fall, sel_rise, active;
	assign sel_fall = sel_d & ~sel_s2;
	assign sel_rise = ~sel_d & sel_s2;
	assign active   = ~sel_s2;

	// ----------------------------------------------------------------
	// bit shifter: one bit, two bits or a nibble per sample
	// ----------------------------------------------------------------
	logic [1:0] lanes;   // 0 single, 1 dual, 2 quad
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [2:0] next_bit_cnt;
	logic       byte_done;
	logic       bit_step;

	// one transfer unit per clock while selected; no host clock here
	assign bit_step = active;

	always_comb
	begin
		next_shreg   = shreg;
		next_bit_cnt = bit_cnt;
		unique case (lanes)
			2'h2:
			begin
				next_shreg   = {shreg[3:0], dq_s2};
				next_bit_cnt = bit_cnt + 3'h4;
			end
			2'h1:
			begin
				next_shreg   = {shreg[5:0], dq_s2[1:0]};
				next_bit_cnt = bit_cnt + 3'h2;
			end
			default:
			begin
				next_shreg   = {shreg[6:0], dq_s2[0]};
				next_bit_cnt = bit_cnt + 3'h1;
			end
		endcase
	end
	assign byte_done = bit_step && (next_bit_cnt == 3'h0);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shreg   <= 8'h00;
			bit_cnt <= 3'h0;
		end
		else if (!active)
		begin
			bit_cnt <= 3'h0;
		end
		else
		begin
			shreg   <= next_shreg;
			bit_cnt <= next_bit_cnt;
		end
	end

	// ----------------------------------------------------------------
	// instruction sequencer
	// ----------------------------------------------------------------
	sfif_state_type state;
	sfif_kind_type  kind;
	logic [2:0]     cnt;
	logic [7:0]     byte_in;
	logic           first;
	logic [7:0]     out_byte;
	logic [7:0]     wr_offset;

	assign byte_in = next_shreg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state      <= SFIF_IDLE;
			kind       <= SFIF_K_NONE;
			cnt        <= 3'h0;
			first      <= 1'b1;
			lanes      <= 2'h0;
			cmd_opcode <= 8'h00;
			cmd_addr   <= 24'h0;
			data_valid <= 1'b0;
			data_byte  <= 8'h00;
			page_offset <= 8'h00;
			wr_offset   <= 8'h00;
			status_write_byte <= 8'h00;
		end
		else
		begin
			data_valid <= 1'b0;
			if (sel_fall || !active)
			begin
				state <= SFIF_IDLE;
				first <= 1'b1;
				lanes <= four_bit_command_mode ? 2'h2 : 2'h0;
			end
			else if (byte_done)
			begin
				first <= 1'b0;
				unique case (state)
					SFIF_IDLE:
						if (first)
						begin
							cmd_opcode <= byte_in;
							cnt        <= 3'h0;
							if (busy && byte_in != `SFIF_OP_RDSR1)
							begin
								// a stale kind would act again at deselect
								kind  <= SFIF_K_NONE;
								state <= SFIF_IGNORE;
							end
							else
							begin
								unique case (byte_in)
									`SFIF_OP_READ, `SFIF_OP_FREAD,
									`SFIF_OP_DOR:
									begin
										kind  <= SFIF_K_READ;
										state <= SFIF_ADDR;
									end
									`SFIF_OP_DIOR:
									begin
										kind  <= SFIF_K_READ;
										state <= SFIF_ADDR;
										lanes <= 2'h1;
									end
									`SFIF_OP_PP:
									begin
										kind  <= SFIF_K_PROG;
										state <= SFIF_ADDR;
									end
									`SFIF_OP_SE, `SFIF_OP_BE32,
									`SFIF_OP_BE64:
									begin
										kind  <= SFIF_K_ERASE;
										state <= SFIF_ADDR;
									end
									`SFIF_OP_CE1, `SFIF_OP_CE2:
									begin
										kind  <= SFIF_K_ERASE;
										state <= SFIF_IGNORE;
									end
									`SFIF_OP_WRSR1, `SFIF_OP_WRSR2:
									begin
										kind  <= SFIF_K_WRSR;
										state <= SFIF_WDATA;
									end
									`SFIF_OP_RDSR1, `SFIF_OP_RDSR2:
									begin
										kind  <= SFIF_K_RDSR;
										state <= SFIF_RDATA;
									end
									`SFIF_OP_RPD_ID:
									begin
										kind  <= SFIF_K_ID;
										state <= SFIF_DUMMY;
									end
									default:
									begin
										kind  <= SFIF_K_NONE;
										state <= SFIF_IGNORE;
									end
								endcase
							end
						end
					SFIF_ADDR:
					begin
						cmd_addr <= {cmd_addr[15:0], byte_in};
						cnt      <= cnt + 3'h1;
						if (cnt == `SFIF_ADDR_BYTES - 3'h1)
						begin
							cnt <= 3'h0;
							wr_offset   <= byte_in;
							if (kind == SFIF_K_PROG)
								state <= SFIF_WDATA;
							else if (kind == SFIF_K_ERASE)
								state <= SFIF_IGNORE;
							else if (cmd_opcode == `SFIF_OP_READ)
								state <= SFIF_RDATA;
							else
								state <= SFIF_DUMMY;
						end
					end
					SFIF_DUMMY:
					begin
						cnt <= cnt + 3'h1;
						if (kind == SFIF_K_ID)
						begin
							if (cnt == `SFIF_ID_DUMMY - 3'h1)
								state <= SFIF_RDATA;
						end
						else
						begin
							state <= SFIF_RDATA;
							if (cmd_opcode == `SFIF_OP_DOR ||
							    cmd_opcode == `SFIF_OP_DIOR)
								lanes <= 2'h1;
						end
					end
					SFIF_WDATA:
					begin
						data_valid <= (kind == SFIF_K_PROG);
						data_byte  <= byte_in;
						status_write_byte <= byte_in;
						// page_offset names the byte handed over now
						if (kind == SFIF_K_PROG)
						begin
							page_offset <= wr_offset;
							wr_offset   <= (wr_offset + 8'h01)
								& `SFIF_PAGE_MASK;
						end
					end
					default:
						state <= state;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// termination: write class acts only on byte boundary at deselect
	// ----------------------------------------------------------------
	logic whole_byte;
	assign whole_byte = (bit_cnt == 3'h0) && !first;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_program      <= 1'b0;
			cmd_erase        <= 1'b0;
			cmd_write_status <= 1'b0;
			write_enable     <= 1'b0;
			vsr_write_enable <= 1'b0;
			four_bit_command_mode <= 1'b0;
			power_down       <= 1'b0;
		end
		else
		begin
			cmd_program      <= 1'b0;
			cmd_erase        <= 1'b0;
			cmd_write_status <= 1'b0;
			if (sel_rise && whole_byte && !busy)
			begin
				if (kind == SFIF_K_PROG && state == SFIF_WDATA
				    && !addr_protected)
					cmd_program <= 1'b1;
				if (kind == SFIF_K_ERASE && state == SFIF_IGNORE
				    && !addr_protected)
					cmd_erase <= 1'b1;
				if (kind == SFIF_K_WRSR && state == SFIF_WDATA)
					cmd_write_status <= 1'b1;
				if (kind != SFIF_K_RDSR)
					vsr_write_enable <= 1'b0;
				unique case (cmd_opcode)
					`SFIF_OP_WREN:    write_enable <= 1'b1;
					`SFIF_OP_WRDI:    write_enable <= 1'b0;
					`SFIF_OP_VSR_WEN: vsr_write_enable <= 1'b1;
					`SFIF_OP_PD:      power_down <= 1'b1;
					`SFIF_OP_QUAD_ON:
						if (quad_enable_bit)
							four_bit_command_mode <= 1'b1;
					`SFIF_OP_QUAD_OFF: four_bit_command_mode <= 1'b0;
					default: ;
				endcase
			end
			if (sel_rise && kind == SFIF_K_ID && !first)
				power_down <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read output: status and id repeat until deselect
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (kind)
			SFIF_K_ID:   out_byte = DEVICE_CODE;
			SFIF_K_RDSR: out_byte = (cmd_opcode == `SFIF_OP_RDSR2) ?
				status_high_byte : status_low_byte;
			default:     out_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dq_out  <= 4'h0;
			dq_oe_b <= 4'hf;
		end
		else if (state == SFIF_RDATA && active)
		begin
			dq_out  <= {3'h0, out_byte[`SFIF_BIT_LAST - bit_cnt]};
			dq_oe_b <= 4'hd;
		end
		else
		begin
			dq_out  <= 4'h0;
			dq_oe_b <= 4'hf;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence desel_s;
		$rose(sel_s2);
	endsequence

	release_drive_a: assert property (@(posedge clk)
		disable iff (!rst_n) !active |=> dq_oe_b == 4'hf)
		else $error("output driven while deselected");
	partial_prog_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		desel_s and bit_cnt != 3'h0 |=> !cmd_program && !cmd_erase)
		else $error("write action on partial byte");
	busy_block_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		busy |=> !cmd_program && !cmd_erase && !cmd_write_status)
		else $error("write action while busy");
	protect_drop_a: assert property (@(posedge clk)
		disable iff (!rst_n) addr_protected |=> !cmd_program && !cmd_erase)
		else $error("protected region altered");
	quad_gate_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(four_bit_command_mode) |-> $past(quad_enable_bit))
		else $error("four-bit mode without quad enable");
	wren_set_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		sel_rise && whole_byte && !busy && cmd_opcode == `SFIF_OP_WREN
		|=> write_enable)
		else $error("write enable not set");
	page_wrap_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		data_valid && page_offset == 8'hff |-> wr_offset == 8'h00)
		else $error("page offset did not wrap");
	opcode_take_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		byte_done && first && state == SFIF_IDLE && active
		|=> cmd_opcode == $past(byte_in))
		else $error("opcode not captured");

endmodule

// ==== hw/sfif_params.svh ====
// constants for the serial flash instruction front end
`ifndef SFIF_PARAMS_SVH
`define SFIF_PARAMS_SVH
`define SFIF_OP_WREN     8'h06
`define SFIF_OP_VSR_WEN  8'h50
`define SFIF_OP_WRDI     8'h04
`define SFIF_OP_RDSR1    8'h05
`define SFIF_OP_RDSR2    8'h35
`define SFIF_OP_WRSR1    8'h01
`define SFIF_OP_WRSR2    8'h31
`define SFIF_OP_READ     8'h03
`define SFIF_OP_FREAD    8'h0b
`define SFIF_OP_PP       8'h02
`define SFIF_OP_SE       8'h20
`define SFIF_OP_BE32     8'h52
`define SFIF_OP_BE64     8'hd8
`define SFIF_OP_CE1      8'hc7
`define SFIF_OP_CE2      8'h60
`define SFIF_OP_PD       8'hb9
`define SFIF_OP_RPD_ID   8'hab
`define SFIF_OP_DOR      8'h3b
`define SFIF_OP_DIOR     8'hbb
`define SFIF_OP_QUAD_ON  8'h38
`define SFIF_OP_QUAD_OFF 8'hff
`define SFIF_ADDR_BYTES  3'h3
`define SFIF_ID_DUMMY    3'h3
`define SFIF_PAGE_MASK   8'hff
`define SFIF_BIT_LAST    3'h7
`define SFIF_CNT_W       3
`endif

// ==== hw/sfif_pkg.sv ====
// types for the serial flash instruction front end
package sfif_pkg;
	typedef enum logic [2:0] {
		SFIF_IDLE,
		SFIF_ADDR,
		SFIF_DUMMY,
		SFIF_WDATA,
		SFIF_RDATA,
		SFIF_IGNORE
	} sfif_state_type;

	typedef enum logic [2:0] {
		SFIF_K_NONE,
		SFIF_K_READ,
		SFIF_K_PROG,
		SFIF_K_ERASE,
		SFIF_K_WRSR,
		SFIF_K_RDSR,
		SFIF_K_ID
	} sfif_kind_type;
endpackage

// ==== test/sfif_host_model.sv ====
// host controller model that frames instructions on select and data lines
`timescale 1ns/10ps
module sfif_host_model
(
	// clock
	input  wire logic       clk,
	// host link
	output logic            select_b,
	output logic      [3:0] dq
);
	initial
	begin
		select_b = 1'b1;
		dq = 4'h0;
	end

	// ---------------------------------------------------------------
	// framing
	// ---------------------------------------------------------------
	// one unit per clock from bit 63 down; n counts bits
	task automatic send(input logic [63:0] d, input int n, input bit quad);
		int i;
		@(posedge clk);
		#10;
		select_b = 1'b0;
		for (i = 0; i < n; i += (quad ? 4 : 1))
		begin
			if (quad)
				dq = d[63-i -: 4];
			else
				dq = {~dq[3:1], d[63-i]};
			@(posedge clk);
			#10;
		end
		select_b = 1'b1;
		// a released line must not keep showing its last value
		dq = ~dq;
		// covers the deselect latency and the idle gap between frames
		repeat (6) @(posedge clk);
		#10;
	endtask
endmodule

// ==== test/sfif_frontend_tb.sv ====
// self-checking testbench for the instruction front end
`timescale 1ns/10ps
`include "sfif_params.svh"
module sfif_frontend_tb;
	logic        clk;
	logic        rst_b;
	logic        select_b;
	logic [3:0]  dq_in;
	logic [3:0]  dq_out;
	logic [3:0]  dq_oe_b;
	logic        busy;
	logic        quad_bit;
	logic [7:0]  st_lo;
	logic [7:0]  st_hi;
	logic        prot;
	logic        wen;
	logic        vwen;
	logic        qmode;
	logic        pdown;
	logic        c_prog;
	logic        c_erase;
	logic        c_wrsr;
	logic [7:0]  c_op;
	logic [23:0] c_addr;
	logic        dvalid;
	logic [7:0]  dbyte;
	logic [7:0]  poff;
	logic [7:0]  sr_byte;
	logic        rd_seen;
	logic [31:0] cmd_q[$];
	logic [15:0] dat_q[$];
	logic        rd_q[$];
	int          errors;
	int          checked;

	localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary value

	sfif_frontend #(.DEVICE_CODE(ID_CODE)) DUT (.clk(clk), .rst_b(rst_b),
		.select_b(select_b),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .busy(busy),
		.quad_enable_bit(quad_bit), .status_low_byte(st_lo),
		.status_high_byte(st_hi), .addr_protected(prot),
		.write_enable(wen), .vsr_write_enable(vwen),
		.four_bit_command_mode(qmode), .power_down(pdown),
		.cmd_program(c_prog), .cmd_erase(c_erase),
		.cmd_write_status(c_wrsr), .cmd_opcode(c_op), .cmd_addr(c_addr),
		.data_valid(dvalid), .data_byte(dbyte), .page_offset(poff),
		.status_write_byte(sr_byte));
	sfif_host_model host (.clk(clk), .select_b(select_b), .dq(dq_in));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic op1(input logic [7:0] op, input bit quad);
		host.send({op, 56'h0}, 8, quad);
	endtask

	// read bits repeat msb first, byte after byte, until deselect
	task automatic expect_bits(input logic [7:0] v, input int n);
		int k;
		for (k = 0; k < n; k++)
			rd_q.push_back(v[7 - (k % 8)]);
	endtask

	// ---------------------------------------------------------------
	// output monitor: every pulse takes the oldest note
	// ---------------------------------------------------------------
	always @(negedge clk)
	begin
		if (c_prog === 1'b1 || c_erase === 1'b1 || c_wrsr === 1'b1)
		begin
			if (cmd_q.size() == 0)
				check("stray command", 32'h1, 32'h0);
			else if (c_wrsr === 1'b1)
				check("status write", {c_op, 16'h0, sr_byte},
					cmd_q.pop_front());
			else
				check("command", {c_op, c_addr}, cmd_q.pop_front());
		end
		if (dvalid === 1'b1)
		begin
			if (dat_q.size() == 0)
				check("stray data", 32'h1, 32'h0);
			else
				check("data", {dbyte, poff}, dat_q.pop_front());
		end
		if (dq_oe_b === 4'hd)
		begin
			rd_seen = 1'b1;
			if (rd_q.size() == 0)
				check("stray read", 32'h1, 32'h0);
			else
				check("read bit", dq_out, {3'h0, rd_q.pop_front()});
		end
	end

	initial
	begin
		#5000000;
		errors++;
		results();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		logic [23:0] a;
		logic [7:0]  b0;
		logic [7:0]  b1;
		logic [7:0]  ops[3];
		int          i;
		rst_b = 1'b0;
		busy = 1'b0;
		quad_bit = 1'b0;
		prot = 1'b0;
		st_lo = 8'h00;
		st_hi = 8'h00;
		rd_seen = 1'b0;
		errors = 0;
		checked = 0;
		ops = '{`SFIF_OP_SE, `SFIF_OP_BE32, `SFIF_OP_BE64};
		void'($urandom(32'h52ca));
		repeat (4) @(posedge clk);
		#10;
		rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#10;
		check("reset enable", dq_oe_b, 4'hf);
		st_lo = 8'($urandom);
		st_hi = 8'($urandom);
		op1(`SFIF_OP_WREN, 1'b0);
		check("write enable", wen, 1'b1);
		op1(`SFIF_OP_WRDI, 1'b0);
		check("write disable", wen, 1'b0);
		op1(`SFIF_OP_VSR_WEN, 1'b0);
		check("volatile enable", vwen, 1'b1);
		for (i = 0; i < 3; i++)
		begin
			a = 24'($urandom);
			op1(`SFIF_OP_WREN, 1'b0);
			cmd_q.push_back({ops[i], a});
			host.send({ops[i], a, 32'h0}, 32, 1'b0);
		end
		// protected region, then a frame one bit short of a byte
		prot = 1'b1;
		op1(`SFIF_OP_WREN, 1'b0);
		host.send({`SFIF_OP_SE, a, 32'h0}, 32, 1'b0);
		prot = 1'b0;
		op1(`SFIF_OP_WREN, 1'b0);
		host.send({`SFIF_OP_SE, a, 32'h0}, 31, 1'b0);
		op1(`SFIF_OP_WRDI, 1'b0);
		busy = 1'b1;
		op1(`SFIF_OP_WREN, 1'b0);
		check("busy ignore", wen, 1'b0);
		expect_bits(st_lo, 8);
		host.send({`SFIF_OP_RDSR1, 56'h0}, 16, 1'b0);
		busy = 1'b0;
		// program starting on the last byte of a page
		a = {16'($urandom), 8'hff};
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		op1(`SFIF_OP_WREN, 1'b0);
		cmd_q.push_back({`SFIF_OP_PP, a});
		dat_q.push_back({b0, 8'hff});
		dat_q.push_back({b1, 8'h00});
		host.send({`SFIF_OP_PP, a, b0, b1, 16'h0}, 48, 1'b0);
		op1(`SFIF_OP_WREN, 1'b0);
		cmd_q.push_back({`SFIF_OP_WRSR1, 16'h0, b0});
		host.send({`SFIF_OP_WRSR1, b0, 48'h0}, 16, 1'b0);
		// status read cut short in mid-byte, after one full repeat
		rd_seen = 1'b0;
		expect_bits(st_lo, 13);
		host.send({`SFIF_OP_RDSR1, 56'h0}, 21, 1'b0);
		check("read drive", rd_seen, 1'b1);
		check("read release", dq_oe_b, 4'hf);
		expect_bits(st_hi, 8);
		host.send({`SFIF_OP_RDSR2, 56'h0}, 16, 1'b0);
		// array data is not modelled; the block returns zero bytes
		a = 24'($urandom);
		expect_bits(8'h00, 8);
		host.send({`SFIF_OP_FREAD, a, 32'h0}, 48, 1'b0);
		check("read address", c_addr, a);
		op1(`SFIF_OP_PD, 1'b0);
		check("power down", pdown, 1'b1);
		expect_bits(ID_CODE, 8);
		host.send({`SFIF_OP_RPD_ID, 56'h0}, 40, 1'b0);
		check("wake", pdown, 1'b0);
		op1(`SFIF_OP_QUAD_ON, 1'b0);
		check("quad refused", qmode, 1'b0);
		quad_bit = 1'b1;
		op1(`SFIF_OP_QUAD_ON, 1'b0);
		check("quad mode", qmode, 1'b1);
		op1(`SFIF_OP_WRDI, 1'b1);
		check("quad disable", wen, 1'b0);
		op1(`SFIF_OP_WREN, 1'b1);
		check("quad enable", wen, 1'b1);
		a = 24'($urandom);
		cmd_q.push_back({`SFIF_OP_BE32, a});
		host.send({`SFIF_OP_BE32, a, 32'h0}, 32, 1'b1);
		op1(`SFIF_OP_QUAD_OFF, 1'b1);
		check("quad exit", qmode, 1'b0);
		i = cmd_q.size() + dat_q.size() + rd_q.size();
		check("notes left", i, 32'h0);
		results();
	end
endmodule
